// [pcdw_top.sv]
// pad control groups, gpio, deep-sleep pad hold and wake capture
// Operation
// - each gpio is output, input or interrupt source, level or edge sensitive
// - pads have tristate driver, drive strength, open-drain, schmitt, pull-up and pull-down
// - pads belong to groups; one setting applies to a whole group
// - in normal operation pad controls come from pinmux registers
// - on deep sleep power control bypasses then resets the pinmux registers
// - pads take fixed states in power-on reset; select pads pulled up; the code pulls up every pad
// - system reset out released first; only then boot configures i/o
// - boot hands over only if table and loader load, else recovery
// - most pads enter deep power down by one common sequence
// - in sleep an input is disabled, a wake source, or another function
// - in sleep an output holds low, high, tristate, or stays dynamic
// - in sleep pulls are forced off or stay configured per pad
// - power control and test port pads never enter deep sleep
// - wake inputs indexed 0 to 71, only some connected
// - pcie wake pin drives wake index 1
// - fault output asserts on internal error needing external handling
// - outputs hold levels during sleep; only a wake event ends it
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pcdw_top #(
   parameter int PADS = 16,
   parameter int GROUPS = 8,
   parameter int HOLD_CYC = pcdw_pkg::RESET_HOLD_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pads
   input wire logic [PADS-1:0] pad_in,
   output logic [PADS-1:0] pad_out,
   output logic [PADS-1:0] pad_oe,
   output logic [PADS-1:0] pad_pull_up,
   output logic [PADS-1:0] pad_pull_down,
   output logic [PADS-1:0] pad_schmitt,
   output logic [2*PADS-1:0] pad_drive,
   output logic [PADS-1:0] pad_deep_power_down,
   // wake sources
   input wire logic [pcdw_pkg::WAKE_COUNT-1:0] wake_in,
   input wire logic pcie_wake_pin_n,
   // system
   output logic system_reset_out_n,
   output logic fault_n,
   output logic sleeping,
   output logic irq
);
   localparam int GW = pcdw_pkg::GC_WIDTH;
   localparam int GA = $clog2(GROUPS);

   // per-pad static attributes
   logic [PADS-1:0] pad_no_sleep = '0;       // power control / test port pads
   logic [PADS-1:0] pad_wake_input = '0;
   logic [PADS-1:0] pad_pull_keep = '0;
   logic [PADS-1:0] pad_out_dynamic = '0;
   logic [31:0] pad_group_map = 32'h76543210; // pad i uses group nibble i%8

   pcdw_pkg::pcdw_state_t state;
   logic [31:0] hold_cnt;
   logic [3:0] ctrl;
   logic [pcdw_pkg::ST_WIDTH-1:0] status, mask;
   logic [6:0] wake_src;
   logic [pcdw_pkg::WAKE_COUNT-1:0] wake_en, wake_latch, wake_all;
   logic [PADS-1:0] gpio_dir, gpio_out, gpio_irq_en, gpio_edge, gpio_prev;
   logic [PADS-1:0] hold_val, hold_oe;
   logic [GROUPS*GW-1:0] grp_all;
   logic [GW-1:0] grp_rdata;
   logic grp_clear, grp_we, rd_grp;
   logic wr, rd;
   logic gpio_event, wake_hit, fault_evt;

   function automatic logic [GA-1:0] pad_group(input int p);
      pad_group = pad_group_map[(p%8)*4 +: GA];
   endfunction

   function automatic logic [6:0] first_index(input logic [pcdw_pkg::WAKE_COUNT-1:0] v);
      first_index = 7'h00;
      for (int i = pcdw_pkg::WAKE_COUNT-1; i >= 0; i--) if (v[i]) first_index = 7'(i);
   endfunction

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;

   // wake vector with pcie pin folded onto its index, active low pin
   always_comb begin
      wake_all = wake_in;
      wake_all[pcdw_pkg::WAKE_PCIE] = wake_in[pcdw_pkg::WAKE_PCIE] | ~pcie_wake_pin_n;
   end

   assign wake_hit = |(wake_all & wake_en);
   assign grp_clear = (state == pcdw_pkg::PCDW_RUN) && ctrl[pcdw_pkg::CTRL_SLEEP_REQ];
   assign grp_we = wr && rd_grp && (state != pcdw_pkg::PCDW_SLEEP);
   assign rd_grp = paddr >= pcdw_pkg::ADDR_GROUP_BASE && paddr < 8'(pcdw_pkg::ADDR_GROUP_BASE + 8'(4 * GROUPS));

   pcdw_grp_mem #(.GROUPS(GROUPS), .WIDTH(GW)) u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .clear(grp_clear),
      .we(grp_we),
      .waddr(paddr[GA+1:2]),
      .wdata(pwdata[GW-1:0]),
      .raddr(paddr[GA+1:2]),
      .rdata(grp_rdata),
      .all_data(grp_all)
   );

   // power sequence: hold reset, boot, run, sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= pcdw_pkg::PCDW_POR;
         hold_cnt <= '0;
      end else begin
         unique case (state)
            pcdw_pkg::PCDW_POR: begin
               hold_cnt <= hold_cnt + 32'h1;
               if (hold_cnt == 32'(HOLD_CYC - 1)) state <= pcdw_pkg::PCDW_BOOT;
            end
            pcdw_pkg::PCDW_BOOT: begin
               if (ctrl[pcdw_pkg::CTRL_BOOT_OK]) state <= pcdw_pkg::PCDW_RUN;
               else if (ctrl[pcdw_pkg::CTRL_BOOT_FAIL]) state <= pcdw_pkg::PCDW_RECOVERY;
            end
            pcdw_pkg::PCDW_RUN: begin
               if (ctrl[pcdw_pkg::CTRL_SLEEP_REQ]) state <= pcdw_pkg::PCDW_SLEEP;
            end
            pcdw_pkg::PCDW_SLEEP: begin
               if (wake_hit) state <= pcdw_pkg::PCDW_RUN;
            end
            pcdw_pkg::PCDW_RECOVERY: begin
               if (ctrl[pcdw_pkg::CTRL_BOOT_OK]) state <= pcdw_pkg::PCDW_RUN;
            end
         endcase
      end
   end

   // control register; sleep request and boot bits self clear once taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= '0;
      end else if (wr && paddr == pcdw_pkg::ADDR_CTRL && state != pcdw_pkg::PCDW_POR) begin
         ctrl <= pwdata[3:0];
      end else begin
         if (state == pcdw_pkg::PCDW_SLEEP) ctrl[pcdw_pkg::CTRL_SLEEP_REQ] <= 1'b0;
         if (state == pcdw_pkg::PCDW_RUN) ctrl[pcdw_pkg::CTRL_BOOT_OK] <= 1'b0;
         if (state == pcdw_pkg::PCDW_RECOVERY) ctrl[pcdw_pkg::CTRL_BOOT_FAIL] <= 1'b0;
      end
   end

   // software registers for wake and gpio; kept through sleep so the wake enables stay armed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= '0;
         wake_en <= '0;
         gpio_dir <= '0;
         gpio_out <= '0;
         gpio_irq_en <= '0;
         gpio_edge <= '0;
      end else if (wr) begin
         unique case (paddr)
            pcdw_pkg::ADDR_MASK: mask <= pwdata[pcdw_pkg::ST_WIDTH-1:0];
            pcdw_pkg::ADDR_WAKE_LO: wake_en[31:0] <= pwdata;
            pcdw_pkg::ADDR_WAKE_MID: wake_en[63:32] <= pwdata;
            pcdw_pkg::ADDR_WAKE_HI: wake_en[71:64] <= pwdata[7:0];
            pcdw_pkg::ADDR_GPIO_DIR: gpio_dir <= pwdata[PADS-1:0];
            pcdw_pkg::ADDR_GPIO_OUT: gpio_out <= pwdata[PADS-1:0];
            pcdw_pkg::ADDR_IRQ_EN: gpio_irq_en <= pwdata[PADS-1:0];
            pcdw_pkg::ADDR_IRQ_EDGE: gpio_edge <= pwdata[PADS-1:0];
            default: ;
         endcase
      end
   end

   // gpio interrupt detection: edge or level per pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gpio_prev <= '0;
      else gpio_prev <= pad_in;
   end
   assign gpio_event = |(gpio_irq_en & ~gpio_dir &
                         ((gpio_edge & pad_in & ~gpio_prev) | (~gpio_edge & pad_in)));

   // latch enabled wakes during sleep and record the first index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_latch <= '0;
         wake_src <= '0;
      end else if (state == pcdw_pkg::PCDW_SLEEP && wake_hit) begin
         wake_latch <= wake_all & wake_en;
         wake_src <= first_index(wake_all & wake_en);
      end
   end

   // fault requested by software or boot failure
   assign fault_evt = ctrl[pcdw_pkg::CTRL_FAULT] || state == pcdw_pkg::PCDW_RECOVERY;

   // sticky status, cleared by read; a same-cycle event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         logic [pcdw_pkg::ST_WIDTH-1:0] ev;
         ev = '0;
         ev[pcdw_pkg::ST_WAKE] = state == pcdw_pkg::PCDW_SLEEP && wake_hit;
         ev[pcdw_pkg::ST_GPIO] = gpio_event;
         ev[pcdw_pkg::ST_FAULT] = fault_evt;
         ev[pcdw_pkg::ST_BOOT] = state == pcdw_pkg::PCDW_BOOT && ctrl[pcdw_pkg::CTRL_BOOT_OK];
         if (rd && paddr == pcdw_pkg::ADDR_STATUS) status <= ev;
         else status <= status | ev;
      end
   end

   // apb ready: no wait state, except one for group reads while the memory read register settles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= (psel && !penable && (pwrite || !rd_grp)) || (psel && penable && !pwrite && rd_grp && !pready);
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               pcdw_pkg::ADDR_CTRL: prdata <= {28'h0, ctrl};
               pcdw_pkg::ADDR_STATUS: prdata <= {28'h0, status};
               pcdw_pkg::ADDR_MASK: prdata <= {28'h0, mask};
               pcdw_pkg::ADDR_WAKE_SRC: prdata <= {25'h0, wake_src};
               pcdw_pkg::ADDR_WAKE_EN: prdata <= {29'h0, 3'(state)};
               pcdw_pkg::ADDR_GPIO_DIR: prdata <= 32'(gpio_dir);
               pcdw_pkg::ADDR_GPIO_OUT: prdata <= 32'(gpio_out);
               pcdw_pkg::ADDR_GPIO_IN: prdata <= 32'(pad_in);
               pcdw_pkg::ADDR_IRQ_EN: prdata <= 32'(gpio_irq_en);
               pcdw_pkg::ADDR_IRQ_EDGE: prdata <= 32'(gpio_edge);
               pcdw_pkg::ADDR_WAKE_LO: prdata <= wake_latch[31:0];
               pcdw_pkg::ADDR_WAKE_MID: prdata <= wake_latch[63:32];
               pcdw_pkg::ADDR_WAKE_HI: prdata <= {24'h0, wake_latch[71:64]};
               default: prdata <= 32'h0;
            endcase
         end else if (psel && penable && !pwrite && rd_grp) begin
            prdata <= 32'(grp_rdata);
         end
      end
   end

   // hold levels captured on entry to sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_val <= '0;
         hold_oe <= '0;
      end else if (grp_clear) begin
         hold_val <= pad_out;
         hold_oe <= pad_oe;
      end
   end

   // pad drive: groups outside sleep (por included), held levels in sleep, fixed safe state while presetn is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out <= '0;
         pad_oe <= '0;
         pad_pull_up <= '1;
         pad_pull_down <= '0;
         pad_schmitt <= '0;
         pad_drive <= '0;
         pad_deep_power_down <= '0;
      end else begin
         for (int p = 0; p < PADS; p++) begin
            logic [GW-1:0] g;
            logic asleep;
            g = grp_all[pad_group(p)*GW +: GW];
            asleep = state == pcdw_pkg::PCDW_SLEEP && !pad_no_sleep[p];
            pad_deep_power_down[p] <= asleep;
            pad_drive[2*p +: 2] <= g[1:0];
            pad_schmitt[p] <= g[pcdw_pkg::GC_SCHMITT] && (!asleep || pad_wake_input[p]);
            if (asleep && !pad_pull_keep[p]) begin
               pad_pull_up[p] <= 1'b0;
               pad_pull_down[p] <= 1'b0;
            end else if (!asleep) begin
               pad_pull_up[p] <= g[pcdw_pkg::GC_PU];
               pad_pull_down[p] <= g[pcdw_pkg::GC_PD];
            end
            if (asleep && !pad_out_dynamic[p]) begin
               pad_out[p] <= hold_val[p];
               pad_oe[p] <= hold_oe[p];
            end else if (g[pcdw_pkg::GC_OD]) begin
               pad_out[p] <= 1'b0;
               pad_oe[p] <= (gpio_dir[p] || g[pcdw_pkg::GC_OE]) && !gpio_out[p];
            end else begin
               pad_out[p] <= gpio_out[p];
               pad_oe[p] <= gpio_dir[p] || g[pcdw_pkg::GC_OE];
            end
         end
      end
   end

   // system outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_reset_out_n <= 1'b0;
         fault_n <= 1'b1;
         sleeping <= 1'b0;
         irq <= 1'b0;
      end else begin
         system_reset_out_n <= state != pcdw_pkg::PCDW_POR;
         fault_n <= !fault_evt;
         sleeping <= state == pcdw_pkg::PCDW_SLEEP;
         irq <= |(status & mask);
      end
   end
endmodule
`default_nettype wire

// [pcdw_pkg.sv]
// shared constants for the pad control and deep-sleep wake block
package pcdw_pkg;
   // apb register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_WAKE_SRC = 8'h0c;
   localparam logic [7:0] ADDR_WAKE_EN = 8'h10;
   localparam logic [7:0] ADDR_GPIO_DIR = 8'h14;
   localparam logic [7:0] ADDR_GPIO_OUT = 8'h18;
   localparam logic [7:0] ADDR_GPIO_IN = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
   localparam logic [7:0] ADDR_IRQ_EDGE = 8'h24;
   localparam logic [7:0] ADDR_WAKE_LO = 8'h28;
   localparam logic [7:0] ADDR_WAKE_MID = 8'h2c;
   localparam logic [7:0] ADDR_WAKE_HI = 8'h30;
   localparam logic [7:0] ADDR_GROUP_BASE = 8'h40;
   // control register field positions
   localparam int CTRL_SLEEP_REQ = 0;
   localparam int CTRL_BOOT_OK = 1;
   localparam int CTRL_BOOT_FAIL = 2;
   localparam int CTRL_FAULT = 3;
   // status / mask bit positions
   localparam int ST_WAKE = 0;
   localparam int ST_GPIO = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_BOOT = 3;
   localparam int ST_WIDTH = 4;
   // group config field positions: [1:0] drive, 2 od, 3 schmitt, 4 pu, 5 pd, 6 oe
   localparam int GC_OD = 2;
   localparam int GC_SCHMITT = 3;
   localparam int GC_PU = 4;
   localparam int GC_PD = 5;
   localparam int GC_OE = 6;
   localparam int GC_WIDTH = 7;
   // reset value of a group config: input, pull-up on (safe for active-low selects)
   localparam logic [6:0] GC_RESET = 7'h10;
   // wake index tied to the shared pcie wake pin
   localparam int WAKE_PCIE = 1;
   localparam int WAKE_COUNT = 72;
   // power-up hold of system reset
   localparam int RESET_HOLD_NS = 1000;
   localparam int CLK_NS = 20;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [2:0] {PCDW_POR, PCDW_BOOT, PCDW_RUN, PCDW_SLEEP, PCDW_RECOVERY} pcdw_state_t;
endpackage

// [pcdw_grp_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// small group configuration memory with registered read data
module pcdw_grp_mem #(
   parameter int GROUPS = 8,
   parameter int WIDTH = 7
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write port and synchronous clear
   input wire logic clear,
   input wire logic we,
   input wire logic [$clog2(GROUPS)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // registered read port
   input wire logic [$clog2(GROUPS)-1:0] raddr,
   output logic [WIDTH-1:0] rdata,
   // full contents for pad drivers
   output logic [GROUPS*WIDTH-1:0] all_data
);
   logic [WIDTH-1:0] mem [GROUPS];

   // clear returns every group to its reset setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < GROUPS; i++) mem[i] <= pcdw_pkg::GC_RESET;
      end else if (clear) begin
         for (int i = 0; i < GROUPS; i++) mem[i] <= pcdw_pkg::GC_RESET;
      end else if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // read data from a register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end

   always_comb begin
      for (int i = 0; i < GROUPS; i++) all_data[i*WIDTH +: WIDTH] = mem[i];
   end
endmodule
`default_nettype wire

// [pcdw_chk.sv]
// concurrent checks on the pad control and wake block ports
`timescale 1ns/1ps
`default_nettype none
module pcdw_chk #(
   parameter int PADS = 16,
   parameter int GROUPS = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // pads and wake
   input wire logic [PADS-1:0] pad_out,
   input wire logic [PADS-1:0] pad_oe,
   input wire logic [PADS-1:0] pad_pull_up,
   input wire logic [PADS-1:0] pad_deep_power_down,
   input wire logic [pcdw_pkg::WAKE_COUNT-1:0] wake_in,
   input wire logic pcie_wake_pin_n,
   // system
   input wire logic system_reset_out_n,
   input wire logic fault_n,
   input wire logic sleeping
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // any request at the wake pins, enabled or not
   logic any_wake;
   assign any_wake = (|wake_in) | ~pcie_wake_pin_n;
   // group config reads take one wait state for the memory read register
   logic grp_rd;
   assign grp_rd = !pwrite && paddr >= pcdw_pkg::ADDR_GROUP_BASE
                   && paddr < 8'(pcdw_pkg::ADDR_GROUP_BASE + 8'(4 * GROUPS));
   apb_ready_a: assert property (psel && !penable && !grp_rd |=> pready) else $error("no ready in access");
   grp_wait_a: assert property (psel && !penable && grp_rd |=> !pready ##1 pready)
      else $error("group read wait state wrong");
   ready_once_a: assert property (pready |=> !pready) else $error("ready held twice");
   no_slverr_a: assert property (pready |-> !pslverr) else $error("slave error raised");
   por_pads_a: assert property (!system_reset_out_n |-> pad_oe == '0 && &pad_pull_up) else $error("pad not in por state");
   boot_order_a: assert property (!system_reset_out_n |-> !sleeping && fault_n) else $error("activity before reset out");
   sleep_hold_a: assert property (sleeping && $past(sleeping) |-> $stable(pad_out) && $stable(pad_oe))
      else $error("pad moved in sleep");
   sleep_dpd_a: assert property (sleeping && $past(sleeping) |-> &pad_deep_power_down) else $error("pad not powered down");
   awake_dpd_a: assert property (!sleeping && !$past(sleeping) |-> pad_deep_power_down == '0)
      else $error("power down while awake");
   wake_cause_a: assert property ($fell(sleeping) |-> $past(any_wake, 1) || $past(any_wake, 2) || $past(any_wake, 3)
      || $past(any_wake, 4)) else $error("left sleep with no wake");
   fault_src_a: assert property ($fell(fault_n) |-> system_reset_out_n) else $error("fault during power up");
endmodule
bind pcdw_top pcdw_chk #(.PADS(PADS), .GROUPS(GROUPS)) u_pcdw_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
   .pad_deep_power_down(pad_deep_power_down), .wake_in(wake_in), .pcie_wake_pin_n(pcie_wake_pin_n),
   .system_reset_out_n(system_reset_out_n), .fault_n(fault_n), .sleeping(sleeping));
`default_nettype wire

// [pcdw_board.sv]
// carrier board peripherals seen through the pads and wake line
`timescale 1ns/1ps
`default_nettype none
module pcdw_board #(
   parameter int PADS = 16
) (
   // clock
   input wire logic pclk,
   // block side of the pads
   input wire logic [PADS-1:0] pad_out,
   input wire logic [PADS-1:0] pad_oe,
   input wire logic [PADS-1:0] pad_pull_up,
   input wire logic [PADS-1:0] pad_pull_down,
   // peripheral drive requests
   input wire logic [PADS-1:0] dev_en,
   input wire logic [PADS-1:0] dev_val,
   input wire logic pcie_req,
   // resolved levels
   output logic [PADS-1:0] pad_in,
   output logic pcie_wake_pin_n
);
   logic [PADS-1:0] flip = '0;
   // a floating pad wanders so a stale level can never pass for a driven one
   always_ff @(posedge pclk) flip <= ~flip;
   // wire level from all drivers, then pulls
   always_comb begin
      for (int i = 0; i < PADS; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (dev_en[i]) pad_in[i] = dev_val[i];
         else if (pad_pull_up[i]) pad_in[i] = 1'b1;
         else if (pad_pull_down[i]) pad_in[i] = 1'b0;
         else pad_in[i] = flip[i];
      end
   end
   // open-drain wake line, pulled high on the board
   assign pcie_wake_pin_n = ~pcie_req;
endmodule
`default_nettype wire

// [pcdw_tb.sv]
// self-checking bench for the pad control and wake block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int PADS = 16;
   localparam int HOLD = 2;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, system_reset_out_n, fault_n, sleeping, irq, pcie_wake_pin_n;
   logic [PADS-1:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_schmitt, pad_deep_power_down;
   logic [PADS-1:0] dev_en = '0;
   logic [PADS-1:0] dev_val = '0;
   logic [PADS-1:0] e_oe, e_pu, e_pd, e_st;
   logic [2*PADS-1:0] pad_drive, e_dr;
   logic [71:0] wake_in = '0;
   logic pcie_req = 1'b0;
   logic [6:0] grp [8];
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   int ks [4] = '{1, 0, 71, 5};
   pcdw_top #(.PADS(PADS), .GROUPS(8), .HOLD_CYC(HOLD)) u_pcdw_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
      .pad_pull_down(pad_pull_down), .pad_schmitt(pad_schmitt), .pad_drive(pad_drive),
      .pad_deep_power_down(pad_deep_power_down), .wake_in(wake_in), .pcie_wake_pin_n(pcie_wake_pin_n),
      .system_reset_out_n(system_reset_out_n), .fault_n(fault_n), .sleeping(sleeping), .irq(irq));
   pcdw_board #(.PADS(PADS)) u_pcdw_board (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .dev_en(dev_en), .dev_val(dev_val),
      .pcie_req(pcie_req), .pad_in(pad_in), .pcie_wake_pin_n(pcie_wake_pin_n));
   // 50 MHz clock
   always #10 pclk = ~pclk;
   // hang guard, generous against roughly 350 cycles of tests
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one apb transfer; request held until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // group reads answer after one wait state; apb waits for ready and takes data there
   task automatic rdg(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wait_sleep(input logic v);
      for (int i = 0; i < 50 && sleeping !== v; i++) @(posedge pclk);
   endtask
   task automatic reset_dut();
      int i;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(32'(pad_oe), 32'h0);
      chk(32'(pad_pull_up), 32'h0000ffff);
      chk(32'(system_reset_out_n), 32'h0);
      presetn <= 1'b1;
      for (i = 0; i < 100 && system_reset_out_n !== 1'b1; i++) @(posedge pclk);
      chk(32'(i >= HOLD), 32'h1);
      apb(1'b0, pcdw_pkg::ADDR_WAKE_EN, 32'h0);
      chk(rd & 32'h7, 32'(pcdw_pkg::PCDW_BOOT));
      $display("reset test done");
   endtask
   task automatic sleep_wake(input int k);
      logic [95:0] en;
      en = 96'h1 << k;
      apb(1'b1, pcdw_pkg::ADDR_WAKE_LO, en[31:0]);
      apb(1'b1, pcdw_pkg::ADDR_WAKE_MID, en[63:32]);
      apb(1'b1, pcdw_pkg::ADDR_WAKE_HI, en[95:64]);
      apb(1'b1, pcdw_pkg::ADDR_CTRL, 32'h1 << pcdw_pkg::CTRL_SLEEP_REQ);
      wait_sleep(1'b1);
      chk(32'(sleeping), 32'h1);
      apb(1'b1, pcdw_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, pcdw_pkg::ADDR_GROUP_BASE, 32'h40);
      rdg(pcdw_pkg::ADDR_GROUP_BASE);
      chk(rd, 32'(pcdw_pkg::GC_RESET));
      wake_in[(k + 1) % 72] <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(32'(sleeping), 32'h1);
      pcie_req <= k == pcdw_pkg::WAKE_PCIE;
      wake_in <= k == pcdw_pkg::WAKE_PCIE ? 72'h0 : 72'h1 << k;
      repeat (2) @(posedge pclk);
      pcie_req <= 1'b0;
      wake_in <= '0;
      wait_sleep(1'b0);
      chk(32'(sleeping), 32'h0);
      apb(1'b0, pcdw_pkg::ADDR_WAKE_SRC, 32'h0);
      chk(rd & 32'h7f, 32'(k));
      apb(1'b0, pcdw_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rd[pcdw_pkg::ST_WAKE]), 32'h1);
      apb(1'b1, pcdw_pkg::ADDR_GROUP_BASE, 32'(grp[0]));
      rdg(pcdw_pkg::ADDR_GROUP_BASE);
      chk(rd, 32'(grp[0]));
      $display("sleep test done for wake %0d", k);
   endtask
   // main sequence
   initial begin
      void'($urandom(32'h4462));
      reset_dut();
      for (int g = 0; g < 8; g++) begin
         grp[g] = 7'($urandom_range(127, 0));
         apb(1'b1, pcdw_pkg::ADDR_GROUP_BASE + 8'(4 * g), 32'(grp[g]));
      end
      for (int g = 0; g < 8; g++) begin
         rdg(pcdw_pkg::ADDR_GROUP_BASE + 8'(4 * g));
         chk(rd, 32'(grp[g]));
      end
      for (int i = 0; i < PADS; i++) begin
         e_oe[i] = grp[i % 8][pcdw_pkg::GC_OE];
         e_pu[i] = grp[i % 8][pcdw_pkg::GC_PU];
         e_pd[i] = grp[i % 8][pcdw_pkg::GC_PD];
         e_st[i] = grp[i % 8][pcdw_pkg::GC_SCHMITT];
         e_dr[2*i+:2] = grp[i % 8][1:0];
      end
      chk({pad_oe, pad_pull_up}, {e_oe, e_pu});
      chk({pad_pull_down, pad_schmitt}, {e_pd, e_st});
      chk(pad_drive, e_dr);
      apb(1'b1, 8'hfc, 32'hffffffff);
      apb(1'b0, 8'hfc, 32'h0);
      chk(rd, 32'h0);
      $display("group test done");
      apb(1'b1, pcdw_pkg::ADDR_CTRL, 32'h1 << pcdw_pkg::CTRL_BOOT_OK);
      apb(1'b0, pcdw_pkg::ADDR_WAKE_EN, 32'h0);
      chk(rd & 32'h7, 32'(pcdw_pkg::PCDW_RUN));
      grp[0] = 7'h00;
      apb(1'b1, pcdw_pkg::ADDR_GROUP_BASE, 32'h0);
      dev_en[0] <= 1'b1;
      apb(1'b1, pcdw_pkg::ADDR_IRQ_EN, 32'h1);
      apb(1'b1, pcdw_pkg::ADDR_IRQ_EDGE, 32'h1);
      apb(1'b1, pcdw_pkg::ADDR_MASK, 32'h0);
      apb(1'b0, pcdw_pkg::ADDR_STATUS, 32'h0);
      dev_val[0] <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(32'(irq), 32'h0);
      apb(1'b1, pcdw_pkg::ADDR_MASK, 32'h1 << pcdw_pkg::ST_GPIO);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      apb(1'b0, pcdw_pkg::ADDR_GPIO_IN, 32'h0);
      chk(32'(rd[0]), 32'h1);
      apb(1'b0, pcdw_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rd[pcdw_pkg::ST_GPIO]), 32'h1);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      $display("gpio interrupt test done");
      foreach (ks[j]) sleep_wake(j == 3 ? int'($urandom_range(71, 2)) : ks[j]);
      apb(1'b1, pcdw_pkg::ADDR_CTRL, 32'h1 << pcdw_pkg::CTRL_FAULT);
      repeat (2) @(posedge pclk);
      chk(32'(fault_n), 32'h0);
      reset_dut();
      apb(1'b1, pcdw_pkg::ADDR_CTRL, 32'h1 << pcdw_pkg::CTRL_BOOT_FAIL);
      apb(1'b0, pcdw_pkg::ADDR_WAKE_EN, 32'h0);
      chk(rd & 32'h7, 32'(pcdw_pkg::PCDW_RECOVERY));
      chk(32'(fault_n), 32'h0);
      $display("fault and recovery test done");
      wrap_up();
   end
endmodule
`default_nettype wire
